//--- inc/rx_align_regs.vh
`ifndef RX_ALIGN_REGS_VH
`define RX_ALIGN_REGS_VH

// ********************************
// Register offsets
// ********************************
`define CREG_CTL        8'h00
`define CREG_ELASTIC    8'h85
`define QREG_ALIGN_EN   8'h04
`define QREG_MODE       8'h05
`define QREG_WATERMARK  8'h0d
`define QREG_SKIP_CFG   8'h0e
`define QREG_SKIP_LO    8'h12
`define QREG_SKIP_HI    8'h13
`define QREG_ALIGN_STAT 8'h82
`define QREG_SYNC_STAT  8'h84
// Address bit that selects the channel register space
`define ADDR_CHAN_BIT   10

// ********************************
// Field positions
// ********************************
`define CTL_LOOP_BIT    5
`define CTL_SYNC_BIT    7
`define EL_URUN_BIT     6
`define EL_ORUN_BIT     7
`define AST_01_BIT      2
`define AST_23_BIT      3
`define SYNC_STAT_LSB   4
`define ALIGN_EN_LSB    4
`define GAP_BIT_FIRST   6
`define GAP_BIT_SECOND  7
`define MODE_FOUR_BIT   0

// ********************************
// Reset values
// ********************************
`define CTL_RST         8'h00
`define ALIGN_EN_RST    8'h00
`define MODE_RST        8'h00
`define WATERMARK_RST   8'h97
`define SKIP_CFG_RST    8'h00
`define SKIP_LO_RST     8'hfd
`define SKIP_HI_RST     8'h01

// ********************************
// Code-groups and counts
// ********************************
`define CODE_A          8'hfb
`define CODE_K          8'hbc
`define CODE_R          8'hfd
`define CODE_IDLE       8'h07
`define CODE_VIOL       8'hee
`define FIFO_DEPTH      5'd16
`define SYNC_COMMAS     3'd4
`define MAX_SKEW        4'd8
`define GAP_MAX         3'd7

// ********************************
// Timing
// ********************************
`define CLK_PERIOD_NS   20
`define REF_PERIOD_NS   160

`endif

//--- verilog/rx_align_ctl.v
// Behaviour
// - Skips added or removed only, never packet data
// - Sixteen-byte elastic buffer per channel
// - Underrun flag per channel, status bit 6
// - Overrun flag per channel, status bit 7
// - Config bits 6,7 select gap multiplier
// - Minimum gap equals pattern length times multiplier
// - No deletion before minimum gap seen
// - A, K, R idles become 0x07 control on rxData
// - Far-end loopback returns data to transmit
// - Sync enable change forces no-sync state
// - Quad bits 4-7 enable aligner, reversed order
// - Resync resets aligner and FIFO control
// - Link-sync status pins, quad status bits 4-7
// - Aligned outputs mirror quad status bits 2,3
// - Aligner deskews lanes into 2x/4x links
// - Every control pin but resync01/resync23 has register equivalent
// - Control indication marks control bytes
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "rx_align_regs.vh"

module rx_align_ctl (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [10:0] regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [7:0]  regRdData,
  input  wire [3:0]  linkClk,
  input  wire [31:0] linkData,
  input  wire [3:0]  linkCtl,
  output reg  [31:0] rxData,
  output reg  [3:0]  rxCtl,
  output reg  [3:0]  rxValid,
  output reg  [31:0] loopData,
  output reg  [3:0]  loopCtl,
  output reg  [3:0]  loopValid,
  input  wire [3:0]  farLoop,
  input  wire [3:0]  syncEnable,
  input  wire [3:0]  alignEnable,
  input  wire        resync01,
  input  wire        resync23,
  output reg  [3:0]  syncStatus,
  output reg         aligned01,
  output reg         aligned23,
  output reg  [3:0]  underrun,
  output reg  [3:0]  overrun
);

  // ********************************
  // Constants and helpers
  // ********************************
  localparam integer REF_DIV  = `REF_PERIOD_NS / `CLK_PERIOD_NS;
  localparam integer DIV_END  = REF_DIV - 1;
  localparam [3:0]   DIV_LAST = DIV_END[3:0];

  // Flat memory index of a channel's buffer slot
  function [5:0] memIdx;
    input [1:0] ch;
    input [3:0] ptr;
    begin
      memIdx = {ch, ptr};
    end
  endfunction

  // Idle converter: randomized idles become the idle character
  function [8:0] idleConv;
    input [8:0] cw;
    begin
      if (cw[8] && (cw[7:0] == `CODE_A || cw[7:0] == `CODE_K || cw[7:0] == `CODE_R)) begin
        idleConv = {1'b1, `CODE_IDLE};
      end else begin
        idleConv = cw;
      end
    end
  endfunction

  // ********************************
  // State
  // ********************************
  reg [7:0] chanCtl_q [0:3];
  reg [7:0] alignEnReg_q;
  reg [7:0] modeReg_q;
  reg [7:0] watermark_q;
  reg [7:0] skipCfg_q;
  reg [7:0] skipLo_q;
  reg [7:0] skipHi_q;

  reg [8:0] fifoMem [0:63];
  reg [4:0] wrPtr_q [0:3];
  reg [4:0] rdPtr_q [0:3];
  reg [2:0] gapCnt_q [0:3];
  reg [2:0] commaCnt_q [0:3];
  reg [3:0] waitCnt_q [0:3];
  reg [7:0] syncPrev_q;

  reg [3:0]  lclkS1_q, lclkS2_q, lclkS3_q;
  reg [31:0] ldatS1_q, ldatS2_q;
  reg [3:0]  lctlS1_q, lctlS2_q;
  reg [1:0]  rsyS1_q, rsyS2_q;
  reg [3:0]  divCnt_q;

  // ********************************
  // Per-channel decisions
  // ********************************
  wire       fourLane = modeReg_q[`MODE_FOUR_BIT];
  wire [3:0] hiMark   = watermark_q[7:4];
  wire [3:0] loMark   = watermark_q[3:0];
  wire       slot     = (divCnt_q == DIV_LAST);
  wire [3:0] wrEv     = lclkS3_q & ~lclkS2_q; // Falling edge: data is mid-bit
  wire [3:0] grp01    = fourLane ? 4'hf : 4'h3;
  wire [3:0] grp23    = fourLane ? 4'h0 : 4'hc;
  wire       rsy01    = rsyS2_q[0];
  wire       rsy23    = rsyS2_q[1] & ~fourLane;
  wire [3:0] rsyCh    = (rsy01 ? grp01 : 4'h0) | (rsy23 ? 4'hc : 4'h0);

  reg [2:0] minGap;
  reg [3:0] syncEff, syncReg, loopEff, alignEff, nonEmpty, headA, okA, grpAll, hold, pop, del, isFull;
  reg [8:0] head [0:3];
  reg [8:0] inWord [0:3];
  reg [4:0] fill [0:3];
  reg       all01, all23;
  integer   c;

  // Buffer fill, skip decisions and aligner hold
  always @* begin
    // Only a pattern length of one byte exists here, so gap = multiplier
    minGap = {1'b0, skipCfg_q[`GAP_BIT_FIRST], skipCfg_q[`GAP_BIT_SECOND]} + 3'd1;
    for (c = 0; c < 4; c = c + 1) begin
      syncReg[c]  = chanCtl_q[c][`CTL_SYNC_BIT];
      syncEff[c]  = syncEnable[c] | syncReg[c];
      loopEff[c]  = farLoop[c] | chanCtl_q[c][`CTL_LOOP_BIT];
      alignEff[c] = alignEnable[c] | alignEnReg_q[`ALIGN_EN_LSB + 3 - c];
      fill[c]     = wrPtr_q[c] - rdPtr_q[c];
      nonEmpty[c] = (fill[c] != 5'd0);
      isFull[c]   = (fill[c] == `FIFO_DEPTH);
      head[c]     = fifoMem[memIdx(c[1:0], rdPtr_q[c][3:0])];
      inWord[c]   = {lctlS2_q[c], ldatS2_q[8*c +: 8]};
      headA[c]    = head[c][8] && (head[c][7:0] == `CODE_A);
      okA[c]      = headA[c] & nonEmpty[c];
      // Skip bytes only may be dropped, and only after a full gap
      del[c] = (inWord[c] == {skipHi_q[0], skipLo_q}) && (fill[c] > {1'b0, hiMark}) &&
               (gapCnt_q[c] >= minGap);
    end
    all01 = &(okA | ~(alignEff & grp01));
    all23 = &(okA | ~(alignEff & grp23));
    for (c = 0; c < 4; c = c + 1) begin
      grpAll[c] = grp01[c] ? all01 : all23;
      // A lane that reaches its align column early waits for the others
      hold[c] = alignEff[c] & okA[c] & ~grpAll[c] & (waitCnt_q[c] != `MAX_SKEW);
      // Below the low mark a skip at the head is read again until the fill reaches the mark
      pop[c] = nonEmpty[c] & ~hold[c] &
               ~((head[c] == {skipHi_q[0], skipLo_q}) && (fill[c] < {1'b0, loMark}));
    end
  end

  // ********************************
  // Input synchronisers and divider
  // ********************************
  // Link pins come from the recovered clock, resync is asynchronous
  always @(posedge clk) begin
    if (sys_rst) begin
      lclkS1_q <= 4'h0;
      lclkS2_q <= 4'h0;
      lclkS3_q <= 4'h0;
      ldatS1_q <= 32'h0;
      ldatS2_q <= 32'h0;
      lctlS1_q <= 4'h0;
      lctlS2_q <= 4'h0;
      rsyS1_q  <= 2'h0;
      rsyS2_q  <= 2'h0;
      divCnt_q <= 4'h0;
    end else begin
      lclkS1_q <= linkClk;
      lclkS2_q <= lclkS1_q;
      lclkS3_q <= lclkS2_q;
      ldatS1_q <= linkData;
      ldatS2_q <= ldatS1_q;
      lctlS1_q <= linkCtl;
      lctlS2_q <= lctlS1_q;
      rsyS1_q  <= {resync23, resync01};
      rsyS2_q  <= rsyS1_q;
      divCnt_q <= slot ? 4'h0 : divCnt_q + 4'h1;
    end
  end

  // ********************************
  // Elastic buffers, link sync, aligner
  // ********************************
  integer i;

  // Write side on link edges, read side on reference slots
  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        wrPtr_q[i]    <= 5'd0;
        rdPtr_q[i]    <= 5'd0;
        gapCnt_q[i]   <= 3'd0;
        commaCnt_q[i] <= 3'd0;
        waitCnt_q[i]  <= 4'd0;
      end
      syncPrev_q <= 8'h00;
      syncStatus <= 4'h0;
      rxData     <= 32'h0;
      rxCtl      <= 4'h0;
      rxValid    <= 4'h0;
      loopData   <= 32'h0;
      loopCtl    <= 4'h0;
      loopValid  <= 4'h0;
      underrun   <= 4'h0;
      overrun    <= 4'h0;
      aligned01  <= 1'b0;
      aligned23  <= 1'b0;
    end else begin
      syncPrev_q <= {syncReg, syncEnable};
      rxValid    <= {4{slot}};
      loopValid  <= {4{slot}} & loopEff;
      for (i = 0; i < 4; i = i + 1) begin
        // Sticky flags clear on a status read; a new event wins
        if (regRd && regAddr[`ADDR_CHAN_BIT] && regAddr[9:8] == i[1:0] &&
            regAddr[7:0] == `CREG_ELASTIC) begin
          underrun[i] <= 1'b0;
          overrun[i]  <= 1'b0;
        end
        // Link state: an edge on the pin or the register bit restarts, even if the other holds the enable
        if ({syncReg[i], syncEnable[i]} != {syncPrev_q[4 + i], syncPrev_q[i]} || !syncEff[i]) begin
          commaCnt_q[i] <= 3'd0;
          syncStatus[i] <= 1'b0;
        end else if (wrEv[i]) begin
          if (inWord[i] == {1'b1, `CODE_VIOL}) begin
            commaCnt_q[i] <= 3'd0;
            syncStatus[i] <= 1'b0;
          end else if (inWord[i] == {1'b1, `CODE_K} && commaCnt_q[i] != `SYNC_COMMAS) begin
            commaCnt_q[i] <= commaCnt_q[i] + 3'd1;
            syncStatus[i] <= (commaCnt_q[i] + 3'd1 == `SYNC_COMMAS);
          end
        end
        // Write side
        if (wrEv[i]) begin
          if (!inWord[i][8]) begin
            gapCnt_q[i] <= 3'd0;
          end else if (gapCnt_q[i] != `GAP_MAX) begin
            gapCnt_q[i] <= gapCnt_q[i] + 3'd1;
          end
          if (!del[i]) begin
            if (isFull[i]) begin
              overrun[i] <= 1'b1;
            end else begin
              fifoMem[memIdx(i[1:0], wrPtr_q[i][3:0])] <= inWord[i];
              wrPtr_q[i] <= wrPtr_q[i] + 5'd1;
            end
          end
        end
        // Read side; an empty buffer gives idle and flags underrun
        if (slot) begin
          if (nonEmpty[i]) begin
            {rxCtl[i], rxData[8*i +: 8]} <= idleConv(head[i]);
            {loopCtl[i], loopData[8*i +: 8]} <= head[i];
          end else begin
            {rxCtl[i], rxData[8*i +: 8]} <= {1'b1, `CODE_IDLE};
            {loopCtl[i], loopData[8*i +: 8]} <= {1'b1, `CODE_IDLE};
            underrun[i] <= 1'b1;
          end
          if (pop[i]) begin
            rdPtr_q[i] <= rdPtr_q[i] + 5'd1;
          end
          waitCnt_q[i] <= hold[i] ? waitCnt_q[i] + 4'd1 : 4'd0;
        end
        // Resync drops buffered bytes and aligner wait of its lanes
        if (rsyCh[i]) begin
          wrPtr_q[i]   <= 5'd0;
          rdPtr_q[i]   <= 5'd0;
          waitCnt_q[i] <= 4'd0;
        end
      end
      // Alignment status per lane group
      if (rsy01 || ((alignEff & grp01 & ~syncStatus) != 4'h0)) begin
        aligned01 <= 1'b0;
      end else if (slot && all01 && ((alignEff & grp01) != 4'h0)) begin
        aligned01 <= 1'b1;
      end
      if (fourLane || rsy23 || ((alignEff & grp23 & ~syncStatus) != 4'h0)) begin
        aligned23 <= 1'b0;
      end else if (slot && all23 && ((alignEff & grp23) != 4'h0)) begin
        aligned23 <= 1'b1;
      end
    end
  end

  // ********************************
  // Register file
  // ********************************
  integer k;

  // Software writes
  always @(posedge clk) begin
    if (sys_rst) begin
      for (k = 0; k < 4; k = k + 1) begin
        chanCtl_q[k] <= `CTL_RST;
      end
      alignEnReg_q <= `ALIGN_EN_RST;
      modeReg_q    <= `MODE_RST;
      watermark_q  <= `WATERMARK_RST;
      skipCfg_q    <= `SKIP_CFG_RST;
      skipLo_q     <= `SKIP_LO_RST;
      skipHi_q     <= `SKIP_HI_RST;
    end else if (regWr) begin
      if (regAddr[`ADDR_CHAN_BIT]) begin
        if (regAddr[7:0] == `CREG_CTL) begin
          chanCtl_q[regAddr[9:8]] <= regWrData;
        end
      end else begin
        case (regAddr[7:0])
          `QREG_ALIGN_EN:  alignEnReg_q <= regWrData;
          `QREG_MODE:      modeReg_q    <= regWrData;
          `QREG_WATERMARK: watermark_q  <= regWrData;
          `QREG_SKIP_CFG:  skipCfg_q    <= regWrData;
          `QREG_SKIP_LO:   skipLo_q     <= regWrData;
          `QREG_SKIP_HI:   skipHi_q     <= regWrData;
          default:         skipHi_q     <= skipHi_q;
        endcase
      end
    end
  end

  reg [7:0] rdMux;

  // Read decode; unmapped offsets read zero
  always @* begin
    rdMux = 8'h00;
    if (regAddr[`ADDR_CHAN_BIT]) begin
      case (regAddr[7:0])
        `CREG_CTL:     rdMux = chanCtl_q[regAddr[9:8]];
        `CREG_ELASTIC: begin
          rdMux[`EL_URUN_BIT] = underrun[regAddr[9:8]];
          rdMux[`EL_ORUN_BIT] = overrun[regAddr[9:8]];
        end
        default:       rdMux = 8'h00;
      endcase
    end else begin
      case (regAddr[7:0])
        `QREG_ALIGN_EN:   rdMux = alignEnReg_q;
        `QREG_MODE:       rdMux = modeReg_q;
        `QREG_WATERMARK:  rdMux = watermark_q;
        `QREG_SKIP_CFG:   rdMux = skipCfg_q;
        `QREG_SKIP_LO:    rdMux = skipLo_q;
        `QREG_SKIP_HI:    rdMux = skipHi_q;
        `QREG_ALIGN_STAT: begin
          rdMux[`AST_01_BIT] = aligned01;
          rdMux[`AST_23_BIT] = aligned23;
        end
        `QREG_SYNC_STAT:  rdMux[`SYNC_STAT_LSB +: 4] = syncStatus;
        default:          rdMux = 8'h00;
      endcase
    end
  end

  // Read data stands the cycle after the strobe
  always @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRd ? rdMux : 8'h00;
    end
  end

endmodule

//--- verification/rx_align_ctl_properties.sv
`timescale 1ns/1ps
`include "rx_align_regs.vh"

module rx_align_ctl_properties (
  input wire        clk,
  input wire        sys_rst,
  input wire [10:0] regAddr,
  input wire        regRd,
  input wire [7:0]  regRdData,
  input wire [31:0] rxData,
  input wire [3:0]  rxCtl,
  input wire [3:0]  rxValid,
  input wire [3:0]  syncEnable,
  input wire [3:0]  syncStatus,
  input wire        aligned01,
  input wire        aligned23,
  input wire [3:0]  underrun,
  input wire [3:0]  overrun
);
  // ********************************
  // Port-level checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Reads of the status offsets
  wire rdEl = regRd && regAddr == 11'h485;
  wire rdSync = regRd && regAddr == 11'h084;
  wire rdAlign = regRd && regAddr == 11'h082;

  // Quiet cycles between two read slots
  sequence slotGap;
    (rxValid == 4'h0) [*7];
  endsequence

  a_read_idle: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  a_slot_period: assert property (rxValid != 4'h0 |-> rxValid == 4'hf ##1 slotGap ##1 rxValid == 4'hf)
    else $error("read slot pulse or period wrong");
  a_idle_convert: assert property (rxValid[0] && rxCtl[0] |->
    rxData[7:0] != `CODE_A && rxData[7:0] != `CODE_K && rxData[7:0] != `CODE_R)
    else $error("idle code-group passed unconverted");
  a_sync_drop: assert property ($changed(syncEnable[0]) |-> ##[1:3] !syncStatus[0])
    else $error("sync kept after enable change");
  a_urun_sticky: assert property (underrun[0] && !rdEl |=> underrun[0])
    else $error("underrun flag lost without read");
  a_orun_sticky: assert property (overrun[0] && !rdEl |=> overrun[0])
    else $error("overrun flag lost without read");
  a_flag_mirror: assert property (rdEl |=> regRdData[7:6] == {$past(overrun[0]), $past(underrun[0])})
    else $error("elastic status bits differ from flags");
  a_sync_mirror: assert property (rdSync |=> regRdData[7:4] == $past(syncStatus))
    else $error("sync status bits differ from outputs");
  a_align_mirror: assert property (rdAlign |=> regRdData[3:2] == {$past(aligned23), $past(aligned01)})
    else $error("aligned bits differ from outputs");
endmodule

bind rx_align_ctl rx_align_ctl_properties u_props (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regRd(regRd), .regRdData(regRdData), .rxData(rxData), .rxCtl(rxCtl), .rxValid(rxValid),
  .syncEnable(syncEnable), .syncStatus(syncStatus), .aligned01(aligned01), .aligned23(aligned23),
  .underrun(underrun), .overrun(overrun));

//--- verification/link_source.sv
`timescale 1ns/1ps
`include "rx_align_regs.vh"

module link_source (
  input  wire        run,
  input  wire        fast,
  input  wire [1:0]  kind,
  output reg  [3:0]  linkClk,
  output reg  [31:0] linkData,
  output reg  [3:0]  linkCtl,
  output reg  [7:0]  count
);
  reg [1:0] r, ph;

  // ********************************
  // Far-end lane source
  // ********************************
  initial begin
    linkClk = 4'h0;
    linkData = 32'h0;
    linkCtl = 4'h0;
    count = 8'h00;
    r = 2'h0;
    ph = 2'h0;
  end

  // Clock halts low between bursts, so stale data must not look held
  always begin
    // Fast lane runs about seven percent over the reference rate
    #(fast ? 75 : 80);
    if (run || linkClk[0]) begin
      linkClk = ~linkClk;
    end else begin
      linkData = ~linkData;
    end
    if (run && linkClk[0]) begin
      r = 2'($urandom % 3);
      if (kind == 2'd1) begin
        linkData = {4{`CODE_K}};
        linkCtl = 4'hf;
      end else if (kind == 2'd2) begin
        linkData = {4{r == 2'd0 ? `CODE_A : (r == 2'd1 ? `CODE_K : `CODE_R)}};
        linkCtl = 4'hf;
      end else if (kind == 2'd3 && ph != 2'd0) begin
        // Two skips per gap, so one may go at a multiplier of one
        linkData = {4{`CODE_R}};
        linkCtl = 4'hf;
        ph = ph - 2'd1;
      end else begin
        linkData = {4{count}};
        linkCtl = 4'h0;
        count = count + 8'h01;
        ph = 2'd2;
      end
    end
  end
endmodule

//--- verification/rx_align_ctl_bench.sv
`timescale 1ns/1ps
`include "rx_align_regs.vh"

module rx_align_ctl_bench;
  reg         clk, sys_rst, regWr, regRd, resync01, resync23, run, fast, watch;
  reg  [10:0] regAddr, a;
  reg  [7:0]  regWrData, v, expByte;
  reg  [3:0]  farLoop, syncEnable, alignEnable;
  reg  [1:0]  kind;
  wire [7:0]  regRdData, linkCount;
  wire [31:0] linkData, rxData, loopData;
  wire [3:0]  linkClk, linkCtl, rxCtl, rxValid, loopCtl, loopValid, syncStatus, underrun, overrun;
  wire        aligned01, aligned23;
  integer     mismatches, checks, cyc, i;

  rx_align_ctl u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .linkClk(linkClk), .linkData(linkData),
    .linkCtl(linkCtl), .rxData(rxData), .rxCtl(rxCtl), .rxValid(rxValid), .loopData(loopData),
    .loopCtl(loopCtl), .loopValid(loopValid), .farLoop(farLoop), .syncEnable(syncEnable),
    .alignEnable(alignEnable), .resync01(resync01), .resync23(resync23), .syncStatus(syncStatus),
    .aligned01(aligned01), .aligned23(aligned23), .underrun(underrun), .overrun(overrun));
  link_source u_link (.run(run), .fast(fast), .kind(kind), .linkClk(linkClk), .linkData(linkData),
    .linkCtl(linkCtl), .count(linkCount));

  // ********************************
  // Helpers
  // ********************************
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [10:0] ad, input [7:0] d);
    begin
      @(posedge clk);
      regAddr <= ad;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [10:0] ad);
    begin
      @(posedge clk);
      regAddr <= ad;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdData;
    end
  endtask
  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // Clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end

  // Fabric bytes: data must arrive in order, idles as converted
  always @(posedge clk) begin
    if (watch && rxValid[0] === 1'b1) begin
      if (rxCtl[0] === 1'b0) begin
        check(rxData[7:0], expByte);
        if (loopValid[0] === 1'b1)
          check({loopCtl[0], loopData[7:0]}, {1'b0, expByte});
        expByte = expByte + 8'h01;
      end else begin
        check(rxData[7:0], `CODE_IDLE);
      end
    end
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    {clk, regWr, regRd, resync01, resync23, run, fast, watch} = 8'h00;
    {regAddr, a, regWrData, expByte, farLoop, syncEnable, alignEnable, kind} = 0;
    {mismatches, checks, cyc} = 0;
    sys_rst = 1'b1;
    v = 8'($urandom(99));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(11'h00d);
    check(v, `WATERMARK_RST);
    rd(11'h004);
    check(v, `ALIGN_EN_RST);
    rd(11'h040);
    check(v, 8'h00);
    // Random write and read back over the quad compensation registers
    for (i = 0; i < 4; i = i + 1) begin
      a = i < 2 ? 11'h00d + 11'(i) : 11'h010 + 11'(i);
      rd(a);
      check(v, i == 0 ? 8'h97 : (i == 1 ? 8'h00 : (i == 2 ? 8'hfd : 8'h01)));
      wr(a, 8'($urandom));
      rd(a);
      check(v, regWrData);
    end
    wr(11'h00e, 8'h00);
    wr(11'h012, 8'hfd);
    wr(11'h013, 8'h01);
    wr(11'h00d, 8'h97);
    wr(11'h084, 8'hff);
    rd(11'h084);
    check(v, 8'h00);
    // Empty buffer underruns
    repeat (20) @(posedge clk);
    check(underrun, 4'hf);
    rd(11'h485);
    check(v[7:6], 2'b01);
    // Equal-rate data, lane 0 looped back
    @(posedge clk);
    farLoop <= 4'h1;
    expByte = linkCount;
    watch = 1'b1;
    run <= 1'b1;
    for (i = 0; i < 400 && loopValid !== 4'h1; i = i + 1) @(posedge clk);
    check(loopValid, 4'h1);
    repeat (800) @(posedge clk);
    farLoop <= 4'h0;
    // Fast lane with skips between data: deletion must keep up
    kind <= 2'd3;
    fast <= 1'b1;
    repeat (3000) @(posedge clk);
    check(overrun, 4'h0);
    watch = 1'b0;
    wr(11'h00e, 8'h40);
    repeat (2000) @(posedge clk);
    check(overrun, 4'hf);
    run <= 1'b0;
    repeat (20) @(posedge clk);
    rd(11'h485);
    check(v[7], 1'b1);
    check(overrun[0], 1'b0);
    // Commas with sync enabled through the channel registers
    wr(11'h00e, 8'h00);
    kind <= 2'd1;
    fast <= 1'b0;
    run <= 1'b1;
    for (i = 0; i < 4; i = i + 1) wr(11'h400 + {1'b0, 2'(i), 8'h00}, 8'h80);
    for (i = 0; i < 600 && syncStatus !== 4'hf; i = i + 1) @(posedge clk);
    check(syncStatus, 4'hf);
    syncEnable <= 4'h1;
    repeat (4) @(posedge clk);
    check(syncStatus[0], 1'b0);
    // Let bytes left over from the overrun phase drain first
    repeat (160) @(posedge clk);
    watch = 1'b1;
    // Random idles, lanes 0/1 aligned by pin
    kind <= 2'd2;
    alignEnable <= 4'h3;
    for (i = 0; i < 1500 && aligned01 !== 1'b1; i = i + 1) @(posedge clk);
    check({aligned23, aligned01}, 2'b01);
    resync01 <= 1'b1;
    repeat (5) @(posedge clk);
    check(aligned01, 1'b0);
    resync01 <= 1'b0;
    // Lanes 2/3 aligned through the quad register
    alignEnable <= 4'h0;
    wr(11'h004, 8'h30);
    for (i = 0; i < 1500 && aligned23 !== 1'b1; i = i + 1) @(posedge clk);
    check(aligned23, 1'b1);
    resync23 <= 1'b1;
    repeat (5) @(posedge clk);
    check(aligned23, 1'b0);
    // Four-lane mode: pair 0/1 status covers lanes 2/3, resync23 ignored
    wr(11'h005, 8'h01);
    for (i = 0; i < 1500 && aligned01 !== 1'b1; i = i + 1) @(posedge clk);
    check({aligned23, aligned01}, 2'b01);
    rd(11'h082);
    check(v, 8'h04);
    give_verdict;
  end
endmodule
